// file: logic/tsi_defines.svh
// register offsets, field positions and vectors of the interrupt controller
`ifndef TSI_DEFINES_SVH
`define TSI_DEFINES_SVH
`define TSI_OFF_MAIN_ENABLE   8'hA8
`define TSI_OFF_FIRST_PRIO    8'hB8
`define TSI_OFF_P1_FLAGS      8'hC0
`define TSI_OFF_P1_ENABLE     8'hE8
`define TSI_OFF_P1_POLARITY   8'hE9
`define TSI_OFF_SECOND_PRIO   8'hF8
`define TSI_OFF_CPU_STATUS    8'hD0
`define TSI_OFF_EVT_STATUS    8'hD1
`define TSI_OFF_EVT_MASK      8'hD2
`define TSI_BIT_GLOBAL        7
`define TSI_BIT_EX0           0
`define TSI_BIT_ET0           1
`define TSI_BIT_EX1           2
`define TSI_BIT_ET1           3
`define TSI_RST_BYTE          8'h00
`define TSI_MAIN_MASK         8'h8F
`define TSI_PRIO0_MASK        8'h0F
`define TSI_VEC_EX0           16'h0003
`define TSI_VEC_TF0           16'h000B
`define TSI_VEC_EX1           16'h0013
`define TSI_VEC_TF1           16'h001B
`define TSI_VEC_P1_BASE       16'h003B
`define TSI_VEC_P1_STEP       16'h0008
`define TSI_NSRC              12
`endif

// file: logic/tsi_pkg.sv
// types of the twelve source interrupt controller
package tsi_pkg;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} tsi_bus_req_t;
	typedef struct packed {
		logic        take;
		logic        high;
		logic [15:0] vector;
	} tsi_irq_req_t;
	typedef enum logic [1:0] {TSI_RUN, TSI_IDLE, TSI_PDOWN} tsi_pwr_t;
endpackage

// file: logic/tsi_sync.sv
// three flop synchroniser with agreement filter for pin inputs
`timescale 1ns/1ns
module tsi_sync #(
	parameter int W = 8
) (
	// clock and reset
	input  wire logic         i_ref_clk,
	input  wire logic         i_nrst,
	// pins in, clean level out
	input  wire logic [W-1:0] i_pin,
	output logic      [W-1:0] o_level
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			// port1 pins idle high on their pull-ups; a zero here would fake a request after reset
			s1_q <= '1;
			s2_q <= '1;
			s3_q <= '1;
		end else begin
			s1_q <= i_pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end
	// a change counts only once the second and third stage agree
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_level <= '1;
		end else begin
			for (int i = 0; i < W; i++) begin
				if (s2_q[i] == s3_q[i]) begin
					o_level[i] <= s3_q[i];
				end
			end
		end
	end
endmodule // tsi_sync

// file: logic/tsi_irq_ctrl.sv
// two level, twelve source interrupt controller with register port
`timescale 1ns/1ns
`include "tsi_defines.svh"
module tsi_irq_ctrl
	import tsi_pkg::*;
(
	// clock and reset
	input  wire logic        i_ref_clk,
	input  wire logic        i_nrst,
	// register port
	input  wire logic [7:0]  i_addr,
	input  wire logic [7:0]  i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [7:0]  o_rdata,
	// request pins and flags from the core side
	input  wire logic        i_ext_line0_request,
	input  wire logic        i_ext_line1_request,
	input  wire logic        i_timer0_overflow_flag,
	input  wire logic        i_timer1_overflow_flag,
	input  wire logic [7:0]  i_port1_lines,
	// processor handshake
	output logic             o_take,
	output logic             o_take_high,
	output logic      [15:0] o_vector,
	input  wire logic        i_ack,
	input  wire logic        i_reti,
	input  wire logic        i_enter_idle,
	input  wire logic        i_enter_pdown,
	output logic             o_wake,
	output logic             o_pdown,
	output logic             o_idle,
	// summary interrupt
	output logic             o_irq
);
	tsi_bus_req_t bus;
	tsi_irq_req_t pick;
	tsi_pwr_t     pwr_q;
	logic [7:0]   main_enable_q;
	logic [7:0]   first_priority_q;
	logic [7:0]   port1_request_flags_q;
	logic [7:0]   port1_line_enable_q;
	logic [7:0]   port1_polarity_q;
	logic [7:0]   second_priority_q;
	logic [2:0]   evt_status_q;
	logic [2:0]   evt_mask_q;
	logic         in_low_q;
	logic         in_high_q;
	logic [7:0]   p1_level;
	logic [7:0]   p1_active;
	logic [11:0]  pend;
	logic [11:0]  prio;
	logic [7:0]   rdata_d;
	logic         take_ok;

	assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

	tsi_sync #(.W(8)) u_sync (
		.i_ref_clk (i_ref_clk),
		.i_nrst    (i_nrst),
		.i_pin     (i_port1_lines),
		.o_level   (p1_level)
	);

	function automatic logic wr_hit(input tsi_bus_req_t b, input logic [7:0] off);
		return b.wr && (b.addr == off);
	endfunction

	// polarity applied to the clean level; no edge detection on these lines
	assign p1_active = ~(p1_level ^ port1_polarity_q);

	// port1 flags: a live request beats a software clear in the same cycle
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			port1_request_flags_q <= `TSI_RST_BYTE;
		end else if (wr_hit(bus, `TSI_OFF_P1_FLAGS)) begin
			port1_request_flags_q <= (port1_request_flags_q & i_wdata) | p1_active;
		end else begin
			port1_request_flags_q <= port1_request_flags_q | p1_active;
		end
	end

	// control registers
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			main_enable_q       <= `TSI_RST_BYTE;
			first_priority_q    <= `TSI_RST_BYTE;
			port1_line_enable_q <= `TSI_RST_BYTE;
			port1_polarity_q    <= `TSI_RST_BYTE;
			second_priority_q   <= `TSI_RST_BYTE;
			evt_mask_q          <= '0;
		end else begin
			if (wr_hit(bus, `TSI_OFF_MAIN_ENABLE))
				main_enable_q <= i_wdata & `TSI_MAIN_MASK;
			if (wr_hit(bus, `TSI_OFF_FIRST_PRIO))
				first_priority_q <= i_wdata & `TSI_PRIO0_MASK;
			if (wr_hit(bus, `TSI_OFF_P1_ENABLE))
				port1_line_enable_q <= i_wdata;
			if (wr_hit(bus, `TSI_OFF_P1_POLARITY))
				port1_polarity_q <= i_wdata;
			if (wr_hit(bus, `TSI_OFF_SECOND_PRIO))
				second_priority_q <= i_wdata;
			if (wr_hit(bus, `TSI_OFF_EVT_MASK))
				evt_mask_q <= i_wdata[2:0];
		end
	end

	// pending and level vectors in polling order:
	// ex0, line5, tf0, line6, ex1, line2, line7, tf1, line3, line8, line4, line9
	always_comb begin
		pend = {
			main_enable_q[`TSI_BIT_EX0] & i_ext_line0_request,
			port1_line_enable_q[3] & port1_request_flags_q[3],
			main_enable_q[`TSI_BIT_ET0] & i_timer0_overflow_flag,
			port1_line_enable_q[4] & port1_request_flags_q[4],
			main_enable_q[`TSI_BIT_EX1] & i_ext_line1_request,
			port1_line_enable_q[0] & port1_request_flags_q[0],
			port1_line_enable_q[5] & port1_request_flags_q[5],
			main_enable_q[`TSI_BIT_ET1] & i_timer1_overflow_flag,
			port1_line_enable_q[1] & port1_request_flags_q[1],
			port1_line_enable_q[6] & port1_request_flags_q[6],
			port1_line_enable_q[2] & port1_request_flags_q[2],
			port1_line_enable_q[7] & port1_request_flags_q[7]
		};
		prio = {
			first_priority_q[`TSI_BIT_EX0], second_priority_q[3],
			first_priority_q[`TSI_BIT_ET0], second_priority_q[4],
			first_priority_q[`TSI_BIT_EX1], second_priority_q[0],
			second_priority_q[5], first_priority_q[`TSI_BIT_ET1],
			second_priority_q[1], second_priority_q[6],
			second_priority_q[2], second_priority_q[7]
		};
	end

	function automatic logic [15:0] vec_of(input int idx);
		case (idx)
			11: return `TSI_VEC_EX0;
			9:  return `TSI_VEC_TF0;
			7:  return `TSI_VEC_EX1;
			4:  return `TSI_VEC_TF1;
			10: return 16'(`TSI_VEC_P1_BASE + 3 * `TSI_VEC_P1_STEP);
			8:  return 16'(`TSI_VEC_P1_BASE + 4 * `TSI_VEC_P1_STEP);
			6:  return `TSI_VEC_P1_BASE;
			5:  return 16'(`TSI_VEC_P1_BASE + 5 * `TSI_VEC_P1_STEP);
			3:  return 16'(`TSI_VEC_P1_BASE + 1 * `TSI_VEC_P1_STEP);
			2:  return 16'(`TSI_VEC_P1_BASE + 6 * `TSI_VEC_P1_STEP);
			1:  return 16'(`TSI_VEC_P1_BASE + 2 * `TSI_VEC_P1_STEP);
			default: return 16'(`TSI_VEC_P1_BASE + 7 * `TSI_VEC_P1_STEP);
		endcase
	endfunction

	// highest level first, then polling order from the top bit down
	always_comb begin
		pick = '0;
		for (int i = 0; i < `TSI_NSRC; i++) begin
			if (pend[i] && !prio[i] && !pick.high) begin
				pick.take   = 1'b1;
				pick.vector = vec_of(i);
			end
		end
		for (int i = 0; i < `TSI_NSRC; i++) begin
			if (pend[i] && prio[i]) begin
				pick.take   = 1'b1;
				pick.high   = 1'b1;
				pick.vector = vec_of(i);
			end
		end
	end

	// a running high routine blocks all; a running low routine blocks low only
	assign take_ok = main_enable_q[`TSI_BIT_GLOBAL] && !in_high_q &&
	                 (pick.high || !in_low_q) && (pwr_q != TSI_PDOWN);

	assign o_take      = pick.take && take_ok;
	assign o_take_high = pick.high;
	assign o_vector    = pick.vector;

	// in-service tracking; return clears the innermost level first
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			in_low_q  <= 1'b0;
			in_high_q <= 1'b0;
		end else if (i_ack && o_take) begin
			if (pick.high)
				in_high_q <= 1'b1;
			else
				in_low_q <= 1'b1;
		end else if (i_reti) begin
			if (in_high_q)
				in_high_q <= 1'b0;
			else
				in_low_q <= 1'b0;
		end
	end

	// power state; power-down leaves only on an enabled port1 request
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			pwr_q <= TSI_RUN;
		end else begin
			case (pwr_q)
				TSI_RUN: begin
					if (i_enter_pdown)
						pwr_q <= TSI_PDOWN;
					else if (i_enter_idle)
						pwr_q <= TSI_IDLE;
				end
				TSI_IDLE: begin
					if (pick.take && main_enable_q[`TSI_BIT_GLOBAL])
						pwr_q <= TSI_RUN;
				end
				TSI_PDOWN: begin
					if (|(port1_line_enable_q & port1_request_flags_q))
						pwr_q <= TSI_RUN;
				end
				default: pwr_q <= TSI_RUN;
			endcase
		end
	end

	assign o_pdown = (pwr_q == TSI_PDOWN);
	assign o_idle  = (pwr_q == TSI_IDLE);
	assign o_wake  = o_pdown && |(port1_line_enable_q & port1_request_flags_q);

	// event status: bit0 accepted, bit1 wake, bit2 port1 flag raised; write one clears
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			evt_status_q <= '0;
		end else begin
			evt_status_q <= (evt_status_q & ~(wr_hit(bus, `TSI_OFF_EVT_STATUS) ? i_wdata[2:0] : 3'h0))
			                | {|p1_active, o_wake, i_ack && o_take};
		end
	end

	assign o_irq = |(evt_status_q & evt_mask_q);

	// read mux; unmapped addresses read zero
	always_comb begin
		case (bus.addr)
			`TSI_OFF_MAIN_ENABLE: rdata_d = main_enable_q;
			`TSI_OFF_FIRST_PRIO:  rdata_d = first_priority_q;
			`TSI_OFF_P1_FLAGS:    rdata_d = port1_request_flags_q;
			`TSI_OFF_P1_ENABLE:   rdata_d = port1_line_enable_q;
			`TSI_OFF_P1_POLARITY: rdata_d = port1_polarity_q;
			`TSI_OFF_SECOND_PRIO: rdata_d = second_priority_q;
			`TSI_OFF_CPU_STATUS:  rdata_d = {4'h0, in_high_q, in_low_q, o_idle, o_pdown};
			`TSI_OFF_EVT_STATUS:  rdata_d = {5'h00, evt_status_q};
			`TSI_OFF_EVT_MASK:    rdata_d = {5'h00, evt_mask_q};
			default:              rdata_d = 8'h00;
		endcase
	end

	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst)
			o_rdata <= 8'h00;
		else if (bus.rd)
			o_rdata <= rdata_d;
		else
			o_rdata <= 8'h00;
	end
endmodule // tsi_irq_ctrl

// file: dv/tsi_irq_props.sv
// checker of the interrupt controller port behaviour
`timescale 1ns/1ns
module tsi_irq_props (
	input wire logic        i_ref_clk,
	input wire logic        i_nrst,
	input wire logic [7:0]  i_addr,
	input wire logic [7:0]  i_wdata,
	input wire logic        i_wr,
	input wire logic        i_rd,
	input wire logic [7:0]  o_rdata,
	input wire logic        i_ack,
	input wire logic        o_take,
	input wire logic        o_take_high,
	input wire logic [15:0] o_vector,
	input wire logic        o_pdown,
	input wire logic        o_wake,
	input wire logic        o_irq
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_nrst);
	sequence s_low_acc; o_take && i_ack && !o_take_high; endsequence
	sequence s_high_acc; o_take && i_ack && o_take_high; endsequence
	property p_rst_quiet; $rose(i_nrst) |-> !o_take && !o_irq; endproperty
	property p_vec_set; o_take |-> o_vector[2:0] == 3'h3 && o_vector <= 16'h0073 &&
		o_vector != 16'h0023 && o_vector != 16'h002B && o_vector != 16'h0033; endproperty
	property p_prio_rsvd; $past(i_rd) && $past(i_addr) == 8'hB8 |-> o_rdata[7:4] == 4'h0; endproperty
	property p_gate_off; i_wr && i_addr == 8'hA8 && !i_wdata[7] |=> !o_take; endproperty
	property p_low_block; s_low_acc |=> !(o_take && !o_take_high); endproperty
	property p_high_block; s_high_acc |=> !o_take; endproperty
	property p_pd_hold; o_pdown && !o_wake |=> o_pdown; endproperty
	property p_pd_exit; o_pdown && o_wake |-> ##[1:2] !o_pdown; endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("request after reset");
	a_vec_set: assert property (p_vec_set) else $error("vector off table");
	a_prio_rsvd: assert property (p_prio_rsvd) else $error("unused priority bits set");
	a_gate_off: assert property (p_gate_off) else $error("take with gate off");
	a_low_block: assert property (p_low_block) else $error("low nested in low");
	a_high_block: assert property (p_high_block) else $error("nest in high");
	a_pd_hold: assert property (p_pd_hold) else $error("power-down left without wake");
	a_pd_exit: assert property (p_pd_exit) else $error("wake ignored");
endmodule // tsi_irq_props
bind tsi_irq_ctrl tsi_irq_props u_props (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ack(i_ack), .o_take(o_take),
	.o_take_high(o_take_high), .o_vector(o_vector), .o_pdown(o_pdown), .o_wake(o_wake), .o_irq(o_irq));

// file: dv/tsi_core_model.sv
// core stand-in that accepts interrupts and returns from them
`timescale 1ns/1ns
module tsi_core_model (
	input  wire logic i_ref_clk,
	input  wire logic i_nrst,
	input  wire logic i_take,
	input  wire logic i_slow,
	input  wire logic i_hold,
	output logic      o_ack,
	output logic      o_reti
);
	logic [1:0] wait_q;
	logic [2:0] run_q;
	logic [1:0] depth_q;
	// nesting depth kept so a pre-empting routine returns before the one it broke into
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_ack <= 1'b0;
			o_reti <= 1'b0;
			wait_q <= 2'h0;
			run_q <= 3'h0;
			depth_q <= 2'h0;
		end else begin
			o_ack <= 1'b0;
			o_reti <= 1'b0;
			wait_q <= 2'h0;
			if (i_take && !o_ack && !i_hold) begin
				if (wait_q >= {i_slow, 1'b0}) o_ack <= 1'b1;
				else wait_q <= wait_q + 2'h1;
			end
			if (o_ack && i_take) begin
				depth_q <= depth_q + 2'h1;
				run_q <= 3'h6;
			end else if (depth_q != 2'h0 && !i_hold) begin
				run_q <= run_q - 3'h1;
				if (run_q == 3'h1) begin
					o_reti <= 1'b1;
					depth_q <= depth_q - 2'h1;
					run_q <= 3'h6;
				end
			end
		end
	end
endmodule // tsi_core_model

// file: dv/twelve_source_two_level_irq_tb.sv
// self-checking bench of the twelve source interrupt controller
`timescale 1ns/1ns
`include "tsi_defines.svh"
module twelve_source_two_level_irq_tb;
	import tsi_pkg::*;
	logic        clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, idle_go = 1'b0, pd_go = 1'b0;
	logic        hold = 1'b1, slow = 1'b0, ack, reti, take, high, wake, pdown, idle, irq;
	logic [7:0]  addr = 8'h00, wdata = 8'h00, lines = 8'hFF, rdata, d;
	logic [3:0]  req = 4'h0;
	logic [15:0] vec;
	logic [11:0] en;
	logic [7:0]  offs [6] = '{8'hA8, 8'hB8, 8'hC0, 8'hE8, 8'hE9, 8'hF8};
	logic [7:0]  msk [6] = '{`TSI_MAIN_MASK, `TSI_PRIO0_MASK, 8'h00, 8'hFF, 8'hFF, 8'hFF};
	int          ord [12] = '{0, 7, 1, 8, 2, 4, 9, 3, 5, 10, 6, 11};
	int          n_errors = 0, samples_checked = 0, n_acc = 0, r;
	always #25 clk = ~clk;
	always @(posedge clk) if (take && ack) n_acc++;
	tsi_irq_ctrl uut (.i_ref_clk(clk), .i_nrst(nrst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
		.o_rdata(rdata), .i_ext_line0_request(req[0]), .i_ext_line1_request(req[2]),
		.i_timer0_overflow_flag(req[1]), .i_timer1_overflow_flag(req[3]), .i_port1_lines(lines),
		.o_take(take), .o_take_high(high), .o_vector(vec), .i_ack(ack), .i_reti(reti), .i_enter_idle(idle_go),
		.i_enter_pdown(pd_go), .o_wake(wake), .o_pdown(pdown), .o_idle(idle), .o_irq(irq));
	tsi_core_model u_core (.i_ref_clk(clk), .i_nrst(nrst), .i_take(take), .i_slow(slow), .i_hold(hold),
		.o_ack(ack), .o_reti(reti));
	function automatic logic [15:0] vec_of(int idx);
		return idx < 4 ? 16'h0003 + 16'(idx) * 16'h0008 : `TSI_VEC_P1_BASE + 16'(idx - 4) * `TSI_VEC_P1_STEP;
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wreg(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk) wr <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk) rd <= 1'b0;
		@(negedge clk) chk(16'(rdata), 16'(exp));
	endtask
	// low byte register holds four classic sources, high byte register the port1 lines
	task automatic put12(input logic [7:0] a0, input logic [7:0] a1, input logic [11:0] w, input logic g);
		wreg(a0, {g, 3'h0, w[3:0]});
		wreg(a1, w[11:4]);
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		#2000000;
		n_errors++;
		stop_test();
	end
	initial begin
		r = $urandom(88);
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		foreach (offs[i]) rchk(offs[i], 8'h00);
		rchk(8'h10, 8'h00);
		foreach (offs[i]) begin
			d = 8'($urandom);
			wreg(offs[i], d);
			rchk(offs[i], d & msk[i]);
			wreg(offs[i], 8'h00);
		end
		$display("done: registers");
		@(posedge clk) req <= 4'hF;
		wreg(offs[4], 8'hFF);
		repeat (6) @(posedge clk);
		for (int k = 0; k < 12; k++) begin
			en = 12'h000;
			for (int j = k; j < 12; j++) en[ord[j]] = 1'b1;
			put12(offs[0], offs[3], en, 1'b1);
			@(negedge clk) chk(vec, vec_of(ord[k]));
		end
		put12(offs[0], offs[3], 12'hFFF, 1'b0);
		@(negedge clk) chk(16'(take), 16'h0000);
		put12(offs[0], offs[3], 12'h000, 1'b1);
		@(negedge clk) chk(16'(take), 16'h0000);
		put12(offs[0], offs[3], 12'hFFF, 1'b1);
		repeat (4) begin
			r = $urandom_range(11);
			put12(offs[1], offs[5], 12'h001 << r, 1'b0);
			@(negedge clk) chk(vec | {high, 15'h0}, vec_of(r) | 16'h8000);
		end
		put12(offs[1], offs[5], 12'h000, 1'b0);
		$display("done: order");
		@(posedge clk) req <= 4'h0;
		wreg(offs[4], 8'h00);
		wreg(offs[2], 8'h00);
		rchk(offs[2], 8'h00);
		r = $urandom_range(7);
		@(posedge clk) lines[r] <= 1'b0;
		repeat (6) @(posedge clk);
		rchk(offs[2], 8'h01 << r);
		wreg(offs[2], 8'h00);
		rchk(offs[2], 8'h01 << r);
		@(posedge clk) lines[r] <= 1'b1;
		repeat (6) @(posedge clk);
		rchk(offs[2], 8'h01 << r);
		wreg(offs[2], 8'h00);
		rchk(offs[2], 8'h00);
		$display("done: flags");
		@(posedge clk) hold <= 1'b0;
		slow <= 1'b1;
		put12(offs[0], offs[3], 12'h003, 1'b1);
		wreg(offs[1], 8'h02);
		@(posedge clk) req <= 4'h1;
		repeat (5) @(posedge clk);
		req <= 4'h3;
		repeat (6) @(posedge clk);
		req <= 4'h0;
		repeat (30) @(posedge clk);
		@(negedge clk) chk(16'(n_acc), 16'h0002);
		chk(16'(irq), 16'h0000);
		wreg(`TSI_OFF_EVT_MASK, 8'h01);
		@(negedge clk) chk(16'(irq), 16'h0001);
		wreg(`TSI_OFF_EVT_STATUS, 8'hFF);
		@(negedge clk) chk(16'(irq), 16'h0000);
		$display("done: service");
		slow <= 1'b0;
		put12(offs[0], offs[3], 12'h011, 1'b1);
		@(posedge clk) pd_go <= 1'b1;
		@(posedge clk) pd_go <= 1'b0;
		req <= 4'h1;
		repeat (4) @(posedge clk);
		@(negedge clk) chk(16'(pdown), 16'h0001);
		chk(16'(wake), 16'h0000);
		@(posedge clk) lines[0] <= 1'b0;
		repeat (8) @(posedge clk);
		@(negedge clk) chk(16'(pdown), 16'h0000);
		@(posedge clk) lines[0] <= 1'b1;
		req <= 4'h0;
		repeat (12) @(posedge clk);
		rchk(`TSI_OFF_EVT_STATUS, 8'h07);
		wreg(offs[2], 8'h00);
		@(posedge clk) idle_go <= 1'b1;
		@(posedge clk) idle_go <= 1'b0;
		@(negedge clk) chk(16'(idle), 16'h0001);
		@(posedge clk) req <= 4'h1;
		repeat (4) @(posedge clk);
		@(negedge clk) chk(16'(idle), 16'h0000);
		$display("done: power");
		stop_test();
	end
endmodule // twelve_source_two_level_irq_tb
